// ### core/asp_pkg.sv
package asp_pkg;
    // falling-edge count thresholds of the serial clock
    localparam logic [4:0] GLITCH_FALLS = 5'h02;  // below this a rise is a glitch
    localparam logic [4:0] WAKE_FALLS   = 5'h0a;  // edges needed to stay powered
    localparam logic [4:0] FRAME_FALLS  = 5'h10;  // edges in a full frame
    localparam logic [4:0] TRACK_FALL_W = 5'h0d;  // track point, 12/10-bit variants
    localparam logic [4:0] TRACK_FALL_N = 5'h0b;  // track point, 8-bit variant
    localparam logic [4:0] CNT_MAX      = 5'h1f;  // counter saturates here
    // result word layout
    localparam int WORD_BITS  = 16;
    localparam int LEAD_ZEROS = 4;
    localparam int RES_MAX    = 12;
    localparam int FIFO_DEPTH = 16;
    // reset values of pins and controls
    localparam logic CS_IDLE   = 1'b1;
    localparam logic SCLK_IDLE = 1'b0;
    localparam logic OE_OFF    = 1'b1;
    localparam logic PWR_AT_RST = 1'b1;

    typedef enum logic [2:0] {
        MODE_NORMAL  = 3'h1,
        MODE_DOWN    = 3'h2,
        MODE_WAKING  = 3'h4
    } asp_mode_t;

    localparam asp_mode_t MODE_AT_RST = MODE_NORMAL;
endpackage

// ### core/asp_fifo.sv
`timescale 1ns/1ps
module asp_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
        logic                        full;
        logic                        empty;
        logic [WIDTH-1:0]            head;
    } asp_fifo_st_t;

    asp_fifo_st_t st_reg;
    asp_fifo_st_t st_next;
    logic         push;
    logic         pop;

    // pointer, count and flag update
    always_comb begin
        st_next = st_reg;
        push    = in_valid && !st_reg.full;
        pop     = out_ready && !st_reg.empty;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr = st_reg.wr + AW'(1);
        end
        if (pop) begin
            st_next.rd = st_reg.rd + AW'(1);
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + (AW+1)'(1);
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - (AW+1)'(1);
        end
        st_next.full  = (st_next.cnt == (AW+1)'(DEPTH));
        st_next.empty = (st_next.cnt == '0);
        st_next.head  = st_next.mem[st_next.rd];  // oldest word kept in its own register
    end

    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg       <= '0;
            st_reg.empty <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready  = !st_reg.full;
    assign out_valid = !st_reg.empty;
    assign out_data  = st_reg.head;  // read data straight from a register
endmodule

// ### core/asp_ctrl.sv
// Overview of operation
// - three modes (normal, power-down, waking); rise timing picks normal or power-down
// - chip-select fall starts sampling and conversion
// - rise after tenth edge: stay powered, abort
// - full frame is sixteen clocks for every variant
// - power-down switches all analog circuitry off
// - rise between second and tenth edge powers down
// - rise before second edge keeps normal mode
// - chip-select fall starts wake from power-down
// - wake completes after sixteen clocks
// - early rise during wake returns to power-down
// - word is four zeros, result, trailing zeros
// - chip-select fall holds sample, drives output
// - track resumes after thirteenth falling edge, eleventh on 8-bit
// - output releases on sixteenth falling edge
`timescale 1ns/1ps
module asp_ctrl #(
    parameter int RES_BITS = 12
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // serial pins from the host
    input  wire logic                cs_n,
    input  wire logic                sclk,
    // serial result pin, three signals
    input  wire logic                serial_result_in,
    output logic                     serial_result_out,
    output logic                     serial_result_oe_n,
    // results from the converter core
    input  wire logic                conv_valid,
    output logic                     conv_ready,
    input  wire logic [RES_BITS-1:0] conv_data,
    // analog control and status
    output logic                     conv_start,
    output logic                     hold_en,
    output logic                     analog_power_en,
    output logic                     power_down_st
);
    localparam int SHIFT_AMT = asp_pkg::RES_MAX - RES_BITS;
    localparam logic [4:0] TRACK_CNT =
        (RES_BITS == 8) ? asp_pkg::TRACK_FALL_N : asp_pkg::TRACK_FALL_W;

    // all frame, mode and pin-sync state in one register
    typedef struct packed {
        logic                cs_s1;
        logic                cs_s2;
        logic                cs_d;
        logic                sclk_s1;
        logic                sclk_s2;
        logic                sclk_d;
        logic [4:0]          fall_cnt;
        logic                active;
        asp_pkg::asp_mode_t  mode;
        logic [asp_pkg::WORD_BITS-1:0] shift;
        logic                dout;
        logic                oe_n;
        logic                hold;
        logic                pwr_en;
        logic                start;
        logic                down;
        logic                ready;
    } asp_ctl_t;

    asp_ctl_t st_reg;
    asp_ctl_t st_next;

    logic                fifo_valid;
    logic                fifo_full_n;
    logic [RES_BITS-1:0] fifo_data;
    logic                fifo_pop;
    logic                cs_fall;
    logic                cs_rise;
    logic                sclk_fall;
    logic                sclk_rise;

    // place a result into the sixteen-bit output word
    function automatic logic [asp_pkg::WORD_BITS-1:0] fmt_word(
        input logic [RES_BITS-1:0] d
    );
        logic [asp_pkg::WORD_BITS-1:0] w;
        w = asp_pkg::WORD_BITS'(d);
        return w << SHIFT_AMT;
    endfunction

    // result buffer between converter core and serial port
    asp_fifo #(
        .WIDTH (RES_BITS),
        .DEPTH (asp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (conv_valid),
        .in_ready  (fifo_full_n),
        .in_data   (conv_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // pin edges, read only from the second and third sync stages
    assign cs_fall   = !st_reg.cs_s2 && st_reg.cs_d;
    assign cs_rise   = st_reg.cs_s2 && !st_reg.cs_d;
    assign sclk_fall = !st_reg.sclk_s2 && st_reg.sclk_d;
    assign sclk_rise = st_reg.sclk_s2 && !st_reg.sclk_d;
    assign fifo_pop  = cs_fall && fifo_valid;

    // frame sequencing and mode decision
    always_comb begin
        st_next         = st_reg;
        st_next.cs_s1   = cs_n;
        st_next.cs_s2   = st_reg.cs_s1;
        st_next.cs_d    = st_reg.cs_s2;
        st_next.sclk_s1 = sclk;
        st_next.sclk_s2 = st_reg.sclk_s1;
        st_next.sclk_d  = st_reg.sclk_s2;
        st_next.start   = 1'b0;
        st_next.ready   = fifo_full_n;
        if (cs_fall) begin
            // sample, start conversion and drive the first zero
            st_next.fall_cnt = '0;
            st_next.active   = 1'b1;
            st_next.start    = 1'b1;
            st_next.hold     = 1'b1;
            st_next.oe_n     = 1'b0;
            st_next.shift    = fifo_valid ? fmt_word(fifo_data) : '0;
            st_next.dout     = st_next.shift[asp_pkg::WORD_BITS-1];
            st_next.shift    = st_next.shift << 1;
            if (st_reg.mode == asp_pkg::MODE_DOWN) begin
                st_next.mode   = asp_pkg::MODE_WAKING;
                st_next.pwr_en = 1'b1;
            end
        end else if (cs_rise) begin
            // end of frame: abort and decide the mode from the count
            st_next.active = 1'b0;
            st_next.oe_n   = asp_pkg::OE_OFF;
            st_next.hold   = 1'b0;
            case (st_reg.mode)
                asp_pkg::MODE_NORMAL: begin
                    if (st_reg.fall_cnt < asp_pkg::GLITCH_FALLS) begin
                        st_next.mode = asp_pkg::MODE_NORMAL;
                    end else if (st_reg.fall_cnt < asp_pkg::WAKE_FALLS) begin
                        st_next.mode   = asp_pkg::MODE_DOWN;
                        st_next.pwr_en = 1'b0;
                        st_next.hold   = 1'b1;
                    end else begin
                        st_next.mode = asp_pkg::MODE_NORMAL;
                    end
                end
                asp_pkg::MODE_WAKING: begin
                    if (st_reg.fall_cnt < asp_pkg::WAKE_FALLS) begin
                        st_next.mode   = asp_pkg::MODE_DOWN;
                        st_next.pwr_en = 1'b0;
                        st_next.hold   = 1'b1;
                    end else begin
                        st_next.mode = asp_pkg::MODE_NORMAL;
                    end
                end
                default: begin
                    st_next.mode = st_reg.mode;
                end
            endcase
            st_next.fall_cnt = '0;
        end else if (!st_reg.cs_s2) begin
            if (sclk_fall) begin
                // count edges and move the next bit out
                if (st_reg.fall_cnt != asp_pkg::CNT_MAX) begin
                    st_next.fall_cnt = st_reg.fall_cnt + 5'h01;
                end
                if (st_reg.active) begin
                    st_next.dout  = st_reg.shift[asp_pkg::WORD_BITS-1];
                    st_next.shift = st_reg.shift << 1;
                    if (st_next.fall_cnt == asp_pkg::FRAME_FALLS) begin
                        st_next.active = 1'b0;
                        st_next.oe_n   = asp_pkg::OE_OFF;
                        if (st_reg.mode == asp_pkg::MODE_WAKING) begin
                            st_next.mode = asp_pkg::MODE_NORMAL;
                        end
                    end
                end
            end else if (sclk_rise) begin
                // return to track once conversion is done, or at wake start
                if (st_reg.active && st_reg.fall_cnt == TRACK_CNT) begin
                    st_next.hold = 1'b0;
                end
                if (st_reg.mode == asp_pkg::MODE_WAKING && st_reg.fall_cnt == '0) begin
                    st_next.hold = 1'b0;
                end
            end
        end
        st_next.down = (st_next.mode == asp_pkg::MODE_DOWN);
    end

    // state register; power-on mode is a fixed guess, fixed by a dummy frame
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg         <= '0;
            st_reg.cs_s1   <= asp_pkg::CS_IDLE;
            st_reg.cs_s2   <= asp_pkg::CS_IDLE;
            st_reg.cs_d    <= asp_pkg::CS_IDLE;
            st_reg.sclk_s1 <= asp_pkg::SCLK_IDLE;
            st_reg.sclk_s2 <= asp_pkg::SCLK_IDLE;
            st_reg.sclk_d  <= asp_pkg::SCLK_IDLE;
            st_reg.mode    <= asp_pkg::MODE_AT_RST;
            st_reg.oe_n    <= asp_pkg::OE_OFF;
            st_reg.pwr_en  <= asp_pkg::PWR_AT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign serial_result_out  = st_reg.dout;
    assign serial_result_oe_n = st_reg.oe_n;
    assign conv_ready         = st_reg.ready;
    assign conv_start         = st_reg.start;
    assign hold_en            = st_reg.hold;
    assign analog_power_en    = st_reg.pwr_en;
    assign power_down_st      = st_reg.down;

    // checks on the frame and mode logic
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // frame start: output driven, sample held, count cleared
    a_fall_drives_out: assert property (cs_fall |=> !st_reg.oe_n && st_reg.hold
        && st_reg.start && st_reg.active && st_reg.fall_cnt == 5'h00)
        else $error("chip-select fall did not start a frame");
    a_start_pulse: assert property (conv_start
        |=> !conv_start)
        else $error("conversion start longer than one cycle");
    a_first_bit_zero: assert property (cs_fall
        |=> !serial_result_out)
        else $error("first bit of the word is not zero");

    // mode decisions at chip-select edges and per-mode power and hold
    a_glitch_keeps_mode: assert property (cs_rise && st_reg.mode == asp_pkg::MODE_NORMAL
        && st_reg.fall_cnt < asp_pkg::GLITCH_FALLS
        |=> st_reg.mode == asp_pkg::MODE_NORMAL)
        else $error("short frame changed the mode");
    a_window_powers_dn: assert property (cs_rise && st_reg.mode == asp_pkg::MODE_NORMAL
        && st_reg.fall_cnt >= asp_pkg::GLITCH_FALLS && st_reg.fall_cnt < asp_pkg::WAKE_FALLS
        |=> st_reg.mode == asp_pkg::MODE_DOWN ##1 !analog_power_en)
        else $error("power-down window not honoured");
    a_late_rise_powered: assert property (cs_rise && st_reg.mode == asp_pkg::MODE_NORMAL
        && st_reg.fall_cnt >= asp_pkg::WAKE_FALLS
        |=> st_reg.pwr_en && st_reg.oe_n && !st_reg.active)
        else $error("late rise lost power or kept driving");
    a_count_cleared: assert property (cs_rise
        |=> st_reg.fall_cnt == 5'h00)
        else $error("edge count not cleared at chip-select rise");
    a_down_analog_off: assert property (st_reg.mode == asp_pkg::MODE_DOWN
        |-> !st_reg.pwr_en && power_down_st)
        else $error("analog powered in power-down");
    a_down_holds: assert property (st_reg.mode == asp_pkg::MODE_DOWN
        |-> st_reg.hold)
        else $error("sample released in power-down");
    a_normal_powered: assert property (st_reg.mode == asp_pkg::MODE_NORMAL
        |-> st_reg.pwr_en)
        else $error("analog unpowered in normal mode");
    a_wake_begins: assert property (cs_fall && st_reg.mode == asp_pkg::MODE_DOWN
        |=> st_reg.mode == asp_pkg::MODE_WAKING ##1 analog_power_en)
        else $error("wake did not begin at chip-select fall");
    a_early_rise_sleeps: assert property (cs_rise && st_reg.mode == asp_pkg::MODE_WAKING
        && st_reg.fall_cnt < asp_pkg::WAKE_FALLS |=> st_reg.mode == asp_pkg::MODE_DOWN)
        else $error("short wake frame left device awake");
    a_wake_tracks: assert property (!st_reg.cs_s2 && !cs_fall && sclk_rise
        && st_reg.mode == asp_pkg::MODE_WAKING && st_reg.fall_cnt == 5'h00
        |=> !st_reg.hold)
        else $error("sample not released at first clock of wake");

    // serial shifting, release and track point
    a_frame_end_hiz: assert property (!st_reg.cs_s2 && sclk_fall && st_reg.active
        && st_reg.fall_cnt == 5'h0f |=> st_reg.oe_n ##1 serial_result_oe_n)
        else $error("output not released on last edge");
    a_idle_released: assert property (!st_reg.active
        |-> st_reg.oe_n)
        else $error("output driven outside a frame");
    a_wake_done: assert property (!st_reg.cs_s2 && sclk_fall && st_reg.active
        && st_reg.mode == asp_pkg::MODE_WAKING && st_reg.fall_cnt == 5'h0f
        |=> st_reg.mode == asp_pkg::MODE_NORMAL)
        else $error("wake not complete after full frame");
    a_track_point: assert property (!st_reg.cs_s2 && sclk_rise && st_reg.active
        && st_reg.fall_cnt == TRACK_CNT |=> !st_reg.hold)
        else $error("track not resumed at conversion end");
    a_bit_on_fall: assert property (!st_reg.cs_s2 && !cs_rise && !sclk_fall
        && !cs_fall |=> $stable(st_reg.dout))
        else $error("output bit changed off a falling edge");

    // main scenarios reached
    c_power_down: cover property (cs_rise && st_reg.mode == asp_pkg::MODE_NORMAL
        && st_reg.fall_cnt == 5'h05);
    c_full_wake: cover property (st_reg.mode == asp_pkg::MODE_WAKING
        ##1 st_reg.mode == asp_pkg::MODE_NORMAL);
    c_full_frame: cover property (st_reg.active && st_reg.fall_cnt == 5'h0f && sclk_fall);
    c_glitch_frame: cover property (cs_rise && st_reg.mode == asp_pkg::MODE_NORMAL
        && st_reg.fall_cnt == 5'h01);
    c_wake_abort: cover property (cs_rise && st_reg.mode == asp_pkg::MODE_WAKING
        && st_reg.fall_cnt == 5'h09);
endmodule

// ### test/asp_host_model.sv
`timescale 1ns/1ps
module asp_host_model (
    // clock
    input  wire logic        clock,
    // serial pins
    output logic             cs_n,
    output logic             sclk,
    output logic             line,
    input  wire logic        serial_result_out,
    input  wire logic        serial_result_oe_n,
    input  wire logic        hold_en,
    // what the last frame captured
    output logic [15:0]      word,
    output logic [15:0]      hold_v,
    output logic [15:0]      oe_v,
    output logic             oe_late
);
    logic last_bit;

    // pins idle: chip-select high, serial clock low
    initial begin
        cs_n = 1'b1;  // idle high between frames
        sclk = 1'b0;
        last_bit = 1'b0;
    end

    // a released pin shows the inverse of the last driven bit
    always @(posedge clock) begin
        if (serial_result_oe_n === 1'b0) begin
            last_bit <= serial_result_out;
        end
    end
    assign line = serial_result_oe_n ? ~last_bit : serial_result_out;

    // one frame of the given number of falls, half = clocks per sclk level
    task automatic frame(input int falls, input int half);
        int k;
        word = 16'h0000;
        hold_v = 16'h0000;
        oe_v = 16'hffff;
        @(negedge clock);
        cs_n = 1'b0;
        repeat (2 * half) @(negedge clock);
        for (k = 0; k < falls; k++) begin
            sclk = 1'b1;
            repeat (half) @(negedge clock);
            // bit k is taken just before fall k+1
            if (k < 16) begin
                word[15-k] = line;  // sixteen-bit readout
                hold_v[k] = hold_en;
                oe_v[k] = serial_result_oe_n;
            end
            sclk = 1'b0;
            repeat (half) @(negedge clock);
        end
        repeat (half + 2) @(negedge clock);
        oe_late = serial_result_oe_n;
        cs_n = 1'b1;  // low held until the asked falls are done
        repeat (4 * half) @(negedge clock);  // quiet time before next fall
    endtask
endmodule

// ### test/asp_ctrl_bench.sv
`timescale 1ns/1ps
module asp_ctrl_bench;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        cs_n;
    logic        sclk;
    logic        line;
    logic        conv_valid;
    logic        conv_ready;
    logic [11:0] conv_data;
    logic        serial_result_out;
    logic        serial_result_oe_n;
    logic        conv_start;
    logic        hold_en;
    logic        analog_power_en;
    logic        power_down_st;
    logic [15:0] word;
    logic [15:0] hold_v;
    logic [15:0] oe_v;
    logic        oe_late;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          n_start = 0;

    // 50 ns clock
    always #25 clock = ~clock;

    // count conversion start pulses, sampled mid-cycle where they stand
    always @(negedge clock) begin
        if (conv_start === 1'b1) begin
            n_start++;
        end
    end

    asp_ctrl #(.RES_BITS(12)) dut_u (
        .clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk),
        .serial_result_in(line), .serial_result_out(serial_result_out),
        .serial_result_oe_n(serial_result_oe_n), .conv_valid(conv_valid),
        .conv_ready(conv_ready), .conv_data(conv_data), .conv_start(conv_start),
        .hold_en(hold_en), .analog_power_en(analog_power_en), .power_down_st(power_down_st)
    );

    asp_host_model host_u (
        .clock(clock), .cs_n(cs_n), .sclk(sclk), .line(line),
        .serial_result_out(serial_result_out), .serial_result_oe_n(serial_result_oe_n),
        .hold_en(hold_en), .word(word), .hold_v(hold_v), .oe_v(oe_v), .oe_late(oe_late)
    );

    // compare helpers
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic results();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic [11:0] pat(input int i);
        return {i[3:0], ~i[3:0], i[3:0]};
    endfunction

    // one result from the converter core, spaced so the late ready settles
    task automatic push(input logic [11:0] d);
        conv_data = d;
        conv_valid = 1'b1;
        @(negedge clock);
        conv_valid = 1'b0;
        repeat (2) @(negedge clock);
    endtask

    // fill the buffer until it refuses, then drain it through full frames
    task automatic fill_and_drain();
        int n;
        int s0;
        n = 0;
        while (conv_ready === 1'b1 && n < 20) begin
            push(pat(n));
            n++;
        end
        chk16(16'(n), 16'h0010);
        if (n >= 20) results();
        repeat (40) @(negedge clock);
        s0 = n_start;
        for (n = 0; n < 16; n++) begin
            host_u.frame(16, 6);
            chk16(word, {4'h0, pat(n)});
            chk16(oe_v, 16'h0000);
            chk1(oe_late, 1'b1);
        end
        chk16(hold_v, 16'h1fff);
        chk1(conv_ready, 1'b1);
        host_u.frame(16, 6);
        chk16(word, 16'h0000);
        chk16(16'(n_start - s0), 16'h0011);
    endtask

    // mode decisions at every boundary count
    task automatic mode_walk();
        host_u.frame(1, 6);
        chk1(power_down_st, 1'b0);
        host_u.frame(2, 6);
        chk1(power_down_st, 1'b1);
        chk1(analog_power_en, 1'b0);
        chk1(serial_result_oe_n, 1'b1);
        chk1(hold_en, 1'b1);
        host_u.frame(9, 6);
        chk1(power_down_st, 1'b1);
        chk1(analog_power_en, 1'b0);
        host_u.frame(10, 10);
        chk1(power_down_st, 1'b0);
        chk1(analog_power_en, 1'b1);
        host_u.frame(9, 6);
        chk1(power_down_st, 1'b1);
        host_u.frame(16, 6);
        chk1(power_down_st, 1'b0);
        push(12'hc35);
        host_u.frame(12, 6);
        chk16(word, 16'h0c30);
        chk1(analog_power_en, 1'b1);
        chk1(serial_result_oe_n, 1'b1);
        host_u.frame(10, 6);
        chk1(power_down_st, 1'b0);
    endtask

    // reset, then the scenarios
    initial begin
        conv_valid = 1'b0;
        conv_data = 12'h000;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        fill_and_drain();
        mode_walk();
        results();
    end
endmodule
